// >>> core/clk_ctrl.sv
/*
  Clock-control register block of a dual-channel converter: APB register
  file, sample clock divider control, fine delay control and pin routing.
  Assumes one clock (pclk, sample clock stand-in) and synchronous inputs.
*/
// Summary of operation
// - pin A: flag, temperature, or off
// - pin B: flag or off
// - divide clock by 1, 2, 4, 8
// - phase delay in half clock cycles
// - realign divider to sync only when enabled
// - negative skew window of zero to three
// - positive skew window of zero to three
// - fine delay gated; enabling pulses soft reset
// - fine delay two's complement, saturating
`timescale 1ns/1ns
module clk_ctrl
  import clk_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clk_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_in,
  input wire logic chan_a_flag,
  input wire logic chan_b_flag,
  input wire logic temp_diode_flag,
  input wire logic low_power_pin,
  output logic threshold_flag_pin_a,
  output logic threshold_flag_pin_a_oe,
  output logic threshold_flag_pin_b,
  output logic threshold_flag_pin_b_oe,
  output logic power_down,
  output logic standby,
  output logic div_clk_en,
  output logic half_cycle_delay,
  output logic [7:0] fine_delay_code,
  output logic datapath_soft_reset
);

  import clk_ctrl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] pin_func;
    logic [1:0] div_ratio;
    logic [3:0] div_phase;
    logic auto_align;
    logic [1:0] neg_win;
    logic [1:0] pos_win;
    logic fine_en;
    logic [7:0] fine_val;
    logic [7:0] fine_code;
    logic soft_reset;
    logic [7:0] rdata;
    logic slverr;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic [8:0] idx;
  logic setup;
  logic wr;
  logic [7:0] status;
  logic [1:0] ratio_active;
  logic [3:0] phase_active;
  logic [2:0] div_count;
  logic div_stalling;
  logic realign_event;

  // ----------------------------------------
  // address decode helpers
  // ----------------------------------------
  function automatic logic [8:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[10:2];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a, input logic w);
    logic [8:0] i;
    logic ok;
    i = reg_index(a);
    ok = 1'b0;
    if (a[ADDR_W-1] || (a[1:0] != 2'h0))
      ok = 1'b0;
    else if (i == IDX_PIN_FUNC || i == IDX_DIV_RATIO || i == IDX_DIV_PHASE)
      ok = 1'b1;
    else if (i == IDX_ALIGN || i == IDX_FINE_EN || i == IDX_FINE_VAL)
      ok = 1'b1;
    else if (i == IDX_DIV_STATUS)
      ok = !w;
    return ok;
  endfunction

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // read data and error are captured in the setup phase, so the
  // access phase completes at once with data straight from flops
  assign idx = reg_index(paddr);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && is_mapped(paddr, 1'b1);
  assign status = {2'h0, ratio_active, div_stalling, div_count};

  always_comb
  begin
    next_st = st;
    next_st.soft_reset = 1'b0;
    if (setup)
    begin
      next_st.slverr = !is_mapped(paddr, pwrite);
      next_st.rdata = 8'h00;
      if (pwrite)
        next_st.rdata = 8'h00;
      else if (idx == IDX_PIN_FUNC)
        next_st.rdata = st.pin_func;
      else if (idx == IDX_DIV_RATIO)
        next_st.rdata = {6'h00, st.div_ratio};
      else if (idx == IDX_DIV_PHASE)
        next_st.rdata = {4'h0, st.div_phase};
      else if (idx == IDX_ALIGN)
        next_st.rdata = {st.auto_align, 3'h0, st.neg_win, st.pos_win};
      else if (idx == IDX_FINE_EN)
        next_st.rdata = {7'h00, st.fine_en};
      else if (idx == IDX_FINE_VAL)
        next_st.rdata = st.fine_val;
      else if (idx == IDX_DIV_STATUS)
        next_st.rdata = status;
    end
    if (wr)
    begin
      if (idx == IDX_PIN_FUNC)
        next_st.pin_func = pwdata[7:0];
      else if (idx == IDX_DIV_RATIO)
        next_st.div_ratio = pwdata[1:0];
      else if (idx == IDX_DIV_PHASE)
        next_st.div_phase = pwdata[3:0];
      else if (idx == IDX_ALIGN)
      begin
        next_st.auto_align = pwdata[ALIGN_AUTO_BIT];
        next_st.neg_win = pwdata[ALIGN_NEG_LSB +: 2];
        next_st.pos_win = pwdata[ALIGN_POS_LSB +: 2];
      end
      else if (idx == IDX_FINE_EN)
      begin
        next_st.fine_en = pwdata[FINE_EN_BIT];
        // only a 0 to 1 change restarts the datapath
        next_st.soft_reset = pwdata[FINE_EN_BIT] && !st.fine_en;
      end
      else if (idx == IDX_FINE_VAL)
        next_st.fine_val = pwdata[7:0];
    end
    next_st.fine_code = st.fine_en ? fine_sat(st.fine_val) : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.pin_func <= RST_PIN_FUNC;
      st.div_ratio <= RST_DIV_RATIO[1:0];
      st.div_phase <= RST_DIV_PHASE[3:0];
      st.auto_align <= RST_ALIGN[ALIGN_AUTO_BIT];
      st.neg_win <= RST_ALIGN[ALIGN_NEG_LSB +: 2];
      st.pos_win <= RST_ALIGN[ALIGN_POS_LSB +: 2];
      st.fine_en <= RST_FINE_EN[FINE_EN_BIT];
      st.fine_val <= RST_FINE_VAL;
    end
    else
      st <= next_st;
  end

  assign pready = 1'b1;
  assign prdata = {24'h000000, st.rdata};
  assign pslverr = st.slverr;
  assign fine_delay_code = st.fine_code;
  assign datapath_soft_reset = st.soft_reset;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  clk_divider_core u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ratio_code(st.div_ratio),
    .phase_code(st.div_phase),
    .auto_align(st.auto_align),
    .neg_window(st.neg_win),
    .pos_window(st.pos_win),
    .sync_in(sync_in),
    .div_tick(div_clk_en),
    .half_cycle_delay(half_cycle_delay),
    .ratio_active(ratio_active),
    .phase_active(phase_active),
    .div_count(div_count),
    .div_stalling(div_stalling),
    .realign_event(realign_event)
  );

  pin_function_mux u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .select_a(st.pin_func[PIN_A_LSB +: 3]),
    .select_b(st.pin_func[PIN_B_LSB +: 3]),
    .low_power_select(st.pin_func[LP_LSB +: 2]),
    .chan_a_flag(chan_a_flag),
    .chan_b_flag(chan_b_flag),
    .temp_diode_flag(temp_diode_flag),
    .low_power_pin(low_power_pin),
    .threshold_flag_pin_a(threshold_flag_pin_a),
    .threshold_flag_pin_a_oe(threshold_flag_pin_a_oe),
    .threshold_flag_pin_b(threshold_flag_pin_b),
    .threshold_flag_pin_b_oe(threshold_flag_pin_b_oe),
    .power_down(power_down),
    .standby(standby)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tick_then(logic [1:0] code);
    div_clk_en ##1 (ratio_active == code);
  endsequence

  sequence s_sync_edge;
    sync_in && !$past(sync_in) && st.auto_align && (ratio_active != 2'h0) && !div_stalling;
  endsequence

  AST_PIN_A_FLAG: assert property ((st.pin_func[2:0] == PIN_SEL_FLAG) |=>
    (threshold_flag_pin_a == $past(chan_a_flag)) && threshold_flag_pin_a_oe)
    else $error("pin A does not follow channel A flag");
  AST_PIN_A_TEMP: assert property ((st.pin_func[2:0] == PIN_SEL_TEMP) |=>
    (threshold_flag_pin_a == $past(temp_diode_flag)))
    else $error("pin A does not follow temperature flag");
  AST_PIN_A_OFF: assert property ((st.pin_func[2:0] == PIN_SEL_OFF) |=> !threshold_flag_pin_a_oe)
    else $error("disabled pin A still driven");
  AST_PIN_B: assert property ((st.pin_func[5:3] == PIN_SEL_FLAG) |=>
    (threshold_flag_pin_b == $past(chan_b_flag)) && threshold_flag_pin_b_oe)
    else $error("pin B does not follow channel B flag");
  AST_PIN_B_OFF: assert property ((st.pin_func[5:3] == PIN_SEL_OFF) |=> !threshold_flag_pin_b_oe)
    else $error("disabled pin B still driven");
  AST_DIV_ONE: assert property ((ratio_active == 2'h0) |-> div_clk_en)
    else $error("undivided clock missed an enable");
  AST_DIV_TWO: assert property (s_tick_then(2'h1) |-> !div_clk_en)
    else $error("divide by 2 period too short");
  AST_DIV_FOUR: assert property (s_tick_then(2'h2) |-> (!div_clk_en)[*3])
    else $error("divide by 4 period too short");
  AST_DIV_EIGHT: assert property (s_tick_then(2'h3) |-> (!div_clk_en)[*7])
    else $error("divide by 8 period too short");
  AST_PHASE_LOAD: assert property (div_clk_en |=> (phase_active == $past(st.div_phase)) &&
    (half_cycle_delay == $past(st.div_phase[0])))
    else $error("phase not taken at divider boundary");
  AST_PHASE_HOLD: assert property (!div_clk_en |=> $stable(phase_active) && $stable(ratio_active))
    else $error("divider setting changed off boundary");
  AST_NO_AUTO: assert property (realign_event |-> $past(st.auto_align) && ($past(ratio_active) != 2'h0))
    else $error("realign without enable or with ratio one");
  AST_POS_WIN: assert property ((s_sync_edge and (div_count == 3'h1) && (st.pos_win != 2'h0))
    |=> !realign_event)
    else $error("realign inside positive window");
  AST_NEG_WIN: assert property ((s_sync_edge and (div_count == div_mask(ratio_active)) &&
    (st.neg_win != 2'h0)) |=> !realign_event)
    else $error("realign inside negative window");
  AST_FINE_OFF: assert property (!st.fine_en |=> (fine_delay_code == 8'h00))
    else $error("fine delay applied while disabled");
  AST_SOFT_RESET: assert property ((wr && (idx == IDX_FINE_EN) && pwdata[0] && !st.fine_en)
    |=> datapath_soft_reset ##1 !datapath_soft_reset)
    else $error("enable did not pulse soft reset");
  AST_FINE_RANGE: assert property (($signed(fine_delay_code) >= $signed(FINE_MIN)) &&
    ($signed(fine_delay_code) <= $signed(FINE_MAX)))
    else $error("fine delay outside span");
  AST_FINE_PASS: assert property ((st.fine_en && $stable(st.fine_val)) |=>
    (fine_delay_code == fine_sat($past(st.fine_val))))
    else $error("fine delay code mismatch");

endmodule

// >>> shared/clk_ctrl_pkg.sv
/*
  Constants, register map and helper functions shared by the clock-control
  block and its divider and pin-function submodules.
  Assumes a single pclk domain and a 32-bit APB register port.
*/
package clk_ctrl_pkg;

  // ----------------------------------------
  // bus and register indices
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [8:0] IDX_PIN_FUNC = 9'h040;
  localparam logic [8:0] IDX_DIV_RATIO = 9'h10B;
  localparam logic [8:0] IDX_DIV_PHASE = 9'h10C;
  localparam logic [8:0] IDX_ALIGN = 9'h10D;
  localparam logic [8:0] IDX_FINE_EN = 9'h117;
  localparam logic [8:0] IDX_FINE_VAL = 9'h118;
  localparam logic [8:0] IDX_DIV_STATUS = 9'h11A;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_PIN_FUNC = 8'h3F;
  localparam logic [7:0] RST_DIV_RATIO = 8'h00;
  localparam logic [7:0] RST_DIV_PHASE = 8'h00;
  localparam logic [7:0] RST_ALIGN = 8'h00;
  localparam logic [7:0] RST_FINE_EN = 8'h00;
  localparam logic [7:0] RST_FINE_VAL = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PIN_A_LSB = 0;
  localparam int PIN_B_LSB = 3;
  localparam int LP_LSB = 6;
  localparam int ALIGN_AUTO_BIT = 7;
  localparam int ALIGN_NEG_LSB = 2;
  localparam int ALIGN_POS_LSB = 0;
  localparam int FINE_EN_BIT = 0;
  localparam int STAT_STALL_BIT = 3;
  localparam int STAT_RATIO_LSB = 4;

  // ----------------------------------------
  // codes and limits
  // ----------------------------------------
  localparam logic [2:0] PIN_SEL_FLAG = 3'h0;
  localparam logic [2:0] PIN_SEL_TEMP = 3'h3;
  localparam logic [2:0] PIN_SEL_OFF = 3'h7;
  localparam logic [1:0] LP_POWER_DOWN = 2'h0;
  localparam logic [1:0] LP_STANDBY = 2'h1;
  localparam logic [7:0] FINE_MIN = 8'hA8;
  localparam logic [7:0] FINE_MAX = 8'h58;

  // count mask for a divide code: N-1 for N = 1, 2, 4, 8
  function automatic logic [2:0] div_mask(input logic [1:0] code);
    logic [3:0] n;
    n = 4'h1 << code;
    return 3'(n - 4'h1);
  endfunction

  // clamp a two's complement fine delay code to the usable span
  function automatic logic [7:0] fine_sat(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if ($signed(v) < $signed(FINE_MIN))
      r = FINE_MIN;
    else if ($signed(v) > $signed(FINE_MAX))
      r = FINE_MAX;
    return r;
  endfunction

endpackage

// >>> core/pin_function_mux.sv
/*
  Output routing for the two threshold flag pins and decode of the
  low-power pin function. Inputs are synchronous to pclk.
*/
`timescale 1ns/1ns
module pin_function_mux
  import clk_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] select_a,
  input wire logic [2:0] select_b,
  input wire logic [1:0] low_power_select,
  input wire logic chan_a_flag,
  input wire logic chan_b_flag,
  input wire logic temp_diode_flag,
  input wire logic low_power_pin,
  output logic threshold_flag_pin_a,
  output logic threshold_flag_pin_a_oe,
  output logic threshold_flag_pin_b,
  output logic threshold_flag_pin_b_oe,
  output logic power_down,
  output logic standby
);

  typedef struct packed {
    logic pin_a;
    logic pin_a_oe;
    logic pin_b;
    logic pin_b_oe;
    logic pdown;
    logic stby;
  } mux_state_t;

  mux_state_t st;
  mux_state_t next_st;

  always_comb
  begin
    next_st = '0;
    // reserved codes leave the pin undriven, same as disabled
    if (select_a == PIN_SEL_FLAG)
    begin
      next_st.pin_a = chan_a_flag;
      next_st.pin_a_oe = 1'b1;
    end
    else if (select_a == PIN_SEL_TEMP)
    begin
      next_st.pin_a = temp_diode_flag;
      next_st.pin_a_oe = 1'b1;
    end
    if (select_b == PIN_SEL_FLAG)
    begin
      next_st.pin_b = chan_b_flag;
      next_st.pin_b_oe = 1'b1;
    end
    next_st.pdown = low_power_pin && (low_power_select == LP_POWER_DOWN);
    next_st.stby = low_power_pin && (low_power_select == LP_STANDBY);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign threshold_flag_pin_a = st.pin_a;
  assign threshold_flag_pin_a_oe = st.pin_a_oe;
  assign threshold_flag_pin_b = st.pin_b;
  assign threshold_flag_pin_b_oe = st.pin_b_oe;
  assign power_down = st.pdown;
  assign standby = st.stby;

endmodule

// >>> core/clk_divider_core.sv
/*
  Integer sample clock divider with phase offset and automatic
  realignment to the alignment input. Produces a one-cycle enable.
  Assumes sync_in is synchronous to pclk.
*/
`timescale 1ns/1ns
module clk_divider_core
  import clk_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] ratio_code,
  input wire logic [3:0] phase_code,
  input wire logic auto_align,
  input wire logic [1:0] neg_window,
  input wire logic [1:0] pos_window,
  input wire logic sync_in,
  output logic div_tick,
  output logic half_cycle_delay,
  output logic [1:0] ratio_active,
  output logic [3:0] phase_active,
  output logic [2:0] div_count,
  output logic div_stalling,
  output logic realign_event
);

  typedef struct packed {
    logic [2:0] cnt;
    logic [2:0] stall;
    logic [1:0] ratio;
    logic [3:0] phase;
    logic sync_prev;
    logic realign;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [2:0] mask;
  logic [2:0] lead;
  logic outside;
  logic do_realign;

  // phase moves only by stretching the period, never shortening it
  always_comb
  begin
    mask = div_mask(st.ratio);
    lead = 3'(mask - st.cnt + 3'h1) & mask;
    outside = (st.cnt != 3'h0) && (st.cnt > {1'b0, pos_window}) && (lead > {1'b0, neg_window});
    do_realign = (st.stall == 3'h0) && sync_in && !st.sync_prev && auto_align && (st.ratio != 2'h0) && outside;
    next_st = st;
    next_st.sync_prev = sync_in;
    next_st.realign = do_realign;
    if (st.stall != 3'h0)
      next_st.stall = st.stall - 3'h1;
    else if (do_realign)
      next_st.stall = lead;
    else if (st.cnt == mask)
    begin
      next_st.cnt = 3'h0;
      next_st.ratio = ratio_code;
      next_st.phase = phase_code;
      next_st.stall = 3'(phase_code[3:1] - st.phase[3:1]) & div_mask(ratio_code);
    end
    else
      next_st.cnt = st.cnt + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign div_tick = (st.stall == 3'h0) && (st.cnt == mask) && !do_realign;
  assign half_cycle_delay = st.phase[0];
  assign ratio_active = st.ratio;
  assign phase_active = st.phase;
  assign div_count = st.cnt;
  assign div_stalling = (st.stall != 3'h0);
  assign realign_event = st.realign;

endmodule

// >>> tb/tb_top.sv
/*
  Self-checking bench for the clock-control block: APB register access,
  pin routing, divider period, phase, realignment windows and fine delay.
  Assumes the block answers APB with its own pready; inputs change at pclk rise.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); n_mismatch++; end end
module tb_top;
  import clk_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sync_in, chan_a_flag, chan_b_flag, temp_diode_flag, low_power_pin;
  logic threshold_flag_pin_a, threshold_flag_pin_a_oe, threshold_flag_pin_b, threshold_flag_pin_b_oe;
  logic power_down, standby, div_clk_en, half_cycle_delay, datapath_soft_reset;
  logic [7:0] fine_delay_code;
  int n_mismatch, total_checks, cyc;
  logic [8:0] ridx [6] = '{IDX_PIN_FUNC, IDX_DIV_RATIO, IDX_DIV_PHASE, IDX_ALIGN, IDX_FINE_EN, IDX_FINE_VAL};
  logic [7:0] rrst [6] = '{RST_PIN_FUNC, RST_DIV_RATIO, RST_DIV_PHASE, RST_ALIGN, RST_FINE_EN, RST_FINE_VAL};
  logic [2:0] pcode [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
  logic [7:0] fvals [8] = '{8'h00, 8'hA8, 8'hA7, 8'h80, 8'h58, 8'h59, 8'h7F, 8'h01};
  logic [7:0] scase [5] = '{8'h00, 8'h80, 8'h83, 8'h8C, 8'h83};
  int skk [5] = '{2, 2, 2, 6, 6};
  int sexp [5] = '{4, 3, 4, 4, 3};

  clk_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sync_in, .chan_a_flag, .chan_b_flag, .temp_diode_flag, .low_power_pin, .threshold_flag_pin_a,
    .threshold_flag_pin_a_oe, .threshold_flag_pin_b, .threshold_flag_pin_b_oe, .power_down, .standby,
    .div_clk_en, .half_cycle_delay, .fine_delay_code, .datapath_soft_reset);

  // ----------------------------------------
  // clock, watchdog, helpers
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  // expected clamp of a two's complement fine code
  function automatic logic [7:0] sat(input logic [7:0] v);
    if ($signed(v) < -88)
      return 8'hA8;
    if ($signed(v) > 88)
      return 8'h58;
    return v;
  endfunction

  function automatic logic [11:0] adr(input logic [8:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction

  task automatic results();
    $display("mismatches %0d of %0d checks", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one APB transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no private limit: only the watchdog may end a stuck transfer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded search for the divided-clock enable, sampled mid-cycle
  task automatic wait_en();
    int t;
    t = 0;
    do
    begin
      @(negedge pclk);
      t++;
    end
    while (div_clk_en !== 1'b1 && t < 20);
    `CHK("enable found", 1'b1, div_clk_en)
  endtask

  task automatic gap(output int g);
    wait_en();
    g = 0;
    do
    begin
      @(negedge pclk);
      g++;
    end
    while (div_clk_en !== 1'b1 && g < 40);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] v, pf;
    logic [3:0] ph;
    int g, g2, cnt;
    {psel, penable, pwrite, sync_in, chan_a_flag, chan_b_flag, temp_diode_flag, low_power_pin} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    void'($urandom(6));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, adr(ridx[i]), 8'h00);
      `CHK("reset value", {24'h000000, rrst[i]}, rd)
      `CHK("pslverr mapped", 1'b0, err)
    end
    // refused places: unmapped, misaligned, high half, read-only status
    apb(1'b0, 12'h000, 8'h00);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h00000000, rd)
    apb(1'b0, adr(IDX_DIV_RATIO) | 12'h001, 8'h00);
    `CHK("misaligned err", 1'b1, err)
    apb(1'b0, 12'h800 | adr(IDX_PIN_FUNC), 8'h00);
    `CHK("high addr err", 1'b1, err)
    apb(1'b1, adr(IDX_DIV_STATUS), 8'hFF);
    `CHK("status write err", 1'b1, err)

    // pin routing over pin select codes 0 to 3, 5 and 7
    for (int i = 0; i < 12; i++)
    begin
      pf = {2'(i % 4), pcode[(i + 2) % 6], pcode[i % 6]};
      if (i == 11)
        pf = 8'($urandom);
      @(posedge pclk);
      {chan_a_flag, chan_b_flag, temp_diode_flag, low_power_pin} <= 4'($urandom);
      apb(1'b1, adr(IDX_PIN_FUNC), pf);
      apb(1'b0, adr(IDX_PIN_FUNC), 8'h00);
      `CHK("pin func rw", {24'h000000, pf}, rd)
      repeat (2) @(negedge pclk);
      `CHK("pin a oe", (pf[2:0] == 3'h0 || pf[2:0] == 3'h3), threshold_flag_pin_a_oe)
      if (pf[2:0] == 3'h0 || pf[2:0] == 3'h3)
        `CHK("pin a", (pf[2:0] == 3'h0) ? chan_a_flag : temp_diode_flag, threshold_flag_pin_a)
      `CHK("pin b oe", (pf[5:3] == 3'h0), threshold_flag_pin_b_oe)
      if (pf[5:3] == 3'h0)
        `CHK("pin b", chan_b_flag, threshold_flag_pin_b)
      `CHK("power down", low_power_pin && pf[7:6] == 2'h0, power_down)
      `CHK("standby", low_power_pin && pf[7:6] == 2'h1, standby)
    end

    // divider period for each ratio code
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, adr(IDX_DIV_RATIO), 8'(c));
      gap(g);
      gap(g);
      `CHK("period", 1 << c, g)
    end

    // phase step at divide by 8: integer part stretches, half shows on flag
    ph = 4'($urandom_range(15, 2));
    apb(1'b1, adr(IDX_DIV_PHASE), {4'h0, ph});
    gap(g);
    g2 = 0;
    do
    begin
      @(negedge pclk);
      g2++;
    end
    while (div_clk_en !== 1'b1 && g2 < 40);
    `CHK("phase stretch", 16 + ph[3:1], g + g2)
    `CHK("half cycle", ph[0], half_cycle_delay)
    apb(1'b0, adr(IDX_DIV_STATUS), 8'h00);
    `CHK("status ratio", 4'h3, rd[7:4])
    `CHK("status err", 1'b0, err)

    // realignment: auto off, windows closed, windows open either side
    for (int s = 0; s < 5; s++)
    begin
      apb(1'b1, adr(IDX_ALIGN), scase[s]);
      gap(g);
      cnt = 0;
      for (int i = 1; i <= 32; i++)
      begin
        @(posedge pclk);
        sync_in <= (i >= skk[s] && i < skk[s] + 2);
        @(negedge pclk);
        if (div_clk_en === 1'b1)
          cnt++;
      end
      `CHK("realign pulses", sexp[s], cnt)
    end

    // fine delay: enable pulses soft reset once, codes saturate
    apb(1'b1, adr(IDX_FINE_VAL), 8'h30);
    repeat (3) @(negedge pclk);
    `CHK("fine gated", 8'h00, fine_delay_code)
    for (int r = 0; r < 2; r++)
    begin
      apb(1'b1, adr(IDX_FINE_EN), 8'h01);
      cnt = 0;
      repeat (4)
      begin
        @(negedge pclk);
        if (datapath_soft_reset === 1'b1)
          cnt++;
      end
      `CHK("soft reset pulses", (r == 0) ? 1 : 0, cnt)
    end
    `CHK("fine applied", 8'h30, fine_delay_code)
    for (int i = 0; i < 10; i++)
    begin
      v = (i < 8) ? fvals[i] : 8'($urandom);
      apb(1'b1, adr(IDX_FINE_VAL), v);
      repeat (3) @(negedge pclk);
      `CHK("fine code", sat(v), fine_delay_code)
    end
    apb(1'b1, adr(IDX_FINE_EN), 8'h00);
    repeat (3) @(negedge pclk);
    `CHK("fine off", 8'h00, fine_delay_code)
    results();
  end
endmodule
